// *** core/qpcd_pkg.sv ***
// Constants and types shared by the quad pot command decoder
package qpcd_pkg;
    // ********************************************************
    // Frame layout
    // ********************************************************
    localparam int BYTE_BITS = 8;
    localparam int POTS = 4;
    localparam int SETTINGS_PER_POT = 4;
    localparam logic [3:0] BIT_CNT_ACK = 4'h8;
    localparam logic [3:0] BIT_CNT_DONE = 4'h9;
    localparam logic [7:0] TAP_MIN = 8'h00;
    localparam logic [7:0] TAP_MAX = 8'hFF;
    localparam logic [7:0] RESET_TAP = 8'h00;
    localparam logic [7:0] RESET_SETTING = 8'h00;

    // ********************************************************
    // Opcodes in the upper nibble of the instruction byte
    // ********************************************************
    localparam logic [3:0] OP_RD_WIPER = 4'h9;
    localparam logic [3:0] OP_WR_WIPER = 4'hA;
    localparam logic [3:0] OP_RD_SETTING = 4'hB;
    localparam logic [3:0] OP_WR_SETTING = 4'hC;
    localparam logic [3:0] OP_XFR_TO_WIPER = 4'hD;
    localparam logic [3:0] OP_XFR_TO_SETTING = 4'hE;
    localparam logic [3:0] OP_GLOBAL_LOAD = 4'h1;
    localparam logic [3:0] OP_GLOBAL_SAVE = 4'h8;
    localparam logic [3:0] OP_INC_DEC = 4'h2;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int WIPER_RESPONSE_DELAY_NS = 1000;
    localparam int WIPER_RESPONSE_CYC =
        (WIPER_RESPONSE_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1
        : (WIPER_RESPONSE_DELAY_NS / CLK_PERIOD_NS);
    localparam int NV_WRITE_TIME_US = 10;
    localparam int NV_WRITE_CYC_DEFAULT =
        (NV_WRITE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ********************************************************
    // Types
    // ********************************************************
    typedef enum logic [2:0] {
        QPCD_IDLE,
        QPCD_ID,
        QPCD_INSTR,
        QPCD_DATA_RX,
        QPCD_DATA_TX,
        QPCD_INC_DEC,
        QPCD_NV_WAIT
    } qpcd_state_t;

    typedef enum logic [1:0] {
        QPCD_PEND_NONE,
        QPCD_PEND_SINGLE,
        QPCD_PEND_GLOBAL
    } qpcd_pend_t;
endpackage

// *** core/qpcd_pin_sync.sv ***
// Pin synchroniser and line event detector for the two-wire link
`timescale 1ns/1ps
module qpcd_pin_sync
    import qpcd_pkg::*;
#(
    parameter int STRAP_W = 4
)
(
    // Clock and control
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire logic ce_in,
    // Raw pins
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic [STRAP_W-1:0] strap_in,
    // Clean events and levels
    output logic scl_rise_out,
    output logic scl_fall_out,
    output logic sda_out,
    output logic start_out,
    output logic stop_out,
    output logic [STRAP_W-1:0] strap_out
);
    logic [1:0] scl_meta;
    logic [1:0] sda_meta;
    logic [STRAP_W-1:0] strap_meta;
    logic [STRAP_W-1:0] strap_sync;
    logic scl_prev;
    logic sda_prev;
    logic [1:0] next_scl_meta;
    logic [1:0] next_sda_meta;
    logic next_scl_prev;
    logic next_sda_prev;

    always_comb
    begin
        next_scl_meta = {scl_meta[0], scl_in};
        next_sda_meta = {sda_meta[0], sda_in};
        next_scl_prev = scl_meta[1];
        next_sda_prev = sda_meta[1];
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            scl_meta <= 2'h3;
            sda_meta <= 2'h3;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
            strap_meta <= '0;
            strap_sync <= '0;
        end
        else if (ce_in)
        begin
            scl_meta <= next_scl_meta;
            sda_meta <= next_sda_meta;
            scl_prev <= next_scl_prev;
            sda_prev <= next_sda_prev;
            strap_meta <= strap_in;
            strap_sync <= strap_meta;
        end
    end

    // Only the second stage and its delayed copy feed edge logic
    assign scl_rise_out = ce_in & scl_meta[1] & ~scl_prev;
    assign scl_fall_out = ce_in & ~scl_meta[1] & scl_prev;
    assign sda_out = sda_meta[1];
    assign start_out = ce_in & scl_meta[1] & scl_prev & sda_prev & ~sda_meta[1];
    assign stop_out = ce_in & scl_meta[1] & scl_prev & ~sda_prev & sda_meta[1];
    assign strap_out = strap_sync;
endmodule

// *** core/qpcd_decoder.sv ***
// Command decoder for a four channel digital potentiometer on a two-wire link
`timescale 1ns/1ps
module qpcd_decoder
    import qpcd_pkg::*;
#(
    parameter int NV_WRITE_CYC = NV_WRITE_CYC_DEFAULT,
    parameter logic [3:0] DEVICE_TYPE = 4'hA // Arbitrary value
)
(
    // Clock, reset and enable
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire logic ce_in,
    // Two-wire link pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // Address straps
    input wire logic [3:0] address_strap_pins_in,
    // Physical wiper taps, pot 0 in the low byte
    output logic [31:0] wiper_tap_out,
    // Status
    output logic nv_busy_out,
    output logic inc_dec_active_out
);
    // ********************************************************
    // Storage and state
    // ********************************************************
    qpcd_state_t state;
    qpcd_state_t next_state;
    qpcd_pend_t pend;
    qpcd_pend_t next_pend;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic [7:0] instr;
    logic [7:0] next_instr;
    logic [7:0] pend_data;
    logic [7:0] next_pend_data;
    logic [3:0] pend_addr;
    logic [3:0] next_pend_addr;
    logic drive_low;
    logic next_drive_low;
    logic master_ack;
    logic next_master_ack;
    logic [31:0] nv_cnt;
    logic [31:0] next_nv_cnt;
    logic [7:0] wiper_position_reg [POTS];
    logic [7:0] next_wiper [POTS];
    logic [7:0] stored_setting_reg [POTS*SETTINGS_PER_POT];
    logic [7:0] next_stored [POTS*SETTINGS_PER_POT];
    logic [7:0] phys_tap [POTS];
    logic [7:0] next_phys_tap [POTS];
    logic [15:0] resp_cnt;
    logic [15:0] next_resp_cnt;

    logic scl_rise;
    logic scl_fall;
    logic sda_lvl;
    logic start_p;
    logic stop_p;
    logic [3:0] strap;
    logic [3:0] opcode;
    logic [1:0] pot_sel;
    logic [1:0] set_idx;
    logic accept;
    logic wiper_differs;
    logic [3:0] rx_addr;

    function automatic logic [3:0] setting_addr(input logic [1:0] pot, input logic [1:0] idx);
        setting_addr = {pot, idx};
    endfunction

    function automatic logic opcode_known(input logic [3:0] op);
        case (op)
            OP_RD_WIPER, OP_WR_WIPER, OP_RD_SETTING, OP_WR_SETTING,
            OP_XFR_TO_WIPER, OP_XFR_TO_SETTING, OP_GLOBAL_LOAD,
            OP_GLOBAL_SAVE, OP_INC_DEC: opcode_known = 1'b1;
            default: opcode_known = 1'b0;
        endcase
    endfunction

    // ********************************************************
    // Pin synchronisation
    // ********************************************************
    qpcd_pin_sync #(
        .STRAP_W(4)
    ) u_sync (
        .clk_sys_in(clk_sys_in),
        .srst_in(srst_in),
        .ce_in(ce_in),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .strap_in(address_strap_pins_in),
        .scl_rise_out(scl_rise),
        .scl_fall_out(scl_fall),
        .sda_out(sda_lvl),
        .start_out(start_p),
        .stop_out(stop_p),
        .strap_out(strap)
    );

    // Don't-care fields are dropped by the opcode handling below
    assign opcode = instr[7:4];
    assign set_idx = instr[3:2];
    assign pot_sel = instr[1:0];
    // Setting address of the byte just received, pot bits high
    assign rx_addr = setting_addr(shreg[1:0], shreg[3:2]);

    // ********************************************************
    // Byte acceptance
    // ********************************************************
    always_comb
    begin
        case (state)
            QPCD_ID: accept = (shreg[7:4] == DEVICE_TYPE) && (shreg[3:0] == strap);
            QPCD_INSTR: accept = opcode_known(shreg[7:4]);
            QPCD_DATA_RX: accept = 1'b1;
            default: accept = 1'b0;
        endcase
    end

    // ********************************************************
    // Protocol and register next state
    // ********************************************************
    always_comb
    begin
        next_state = state;
        next_pend = pend;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_instr = instr;
        next_pend_data = pend_data;
        next_pend_addr = pend_addr;
        next_drive_low = drive_low;
        next_master_ack = master_ack;
        next_nv_cnt = nv_cnt;
        next_wiper = wiper_position_reg;
        next_stored = stored_setting_reg;
        if (state == QPCD_NV_WAIT)
        begin
            // Bus is deaf until the nonvolatile cycle ends
            next_drive_low = 1'b0;
            next_nv_cnt = nv_cnt + 32'h1;
            if (nv_cnt >= 32'(NV_WRITE_CYC - 1))
            begin
                if (pend == QPCD_PEND_GLOBAL)
                begin
                    for (int p = 0; p < POTS; p++)
                    begin
                        next_stored[setting_addr(2'(p), pend_addr[1:0])] =
                            wiper_position_reg[p];
                    end
                end
                else
                begin
                    next_stored[pend_addr] = pend_data;
                end
                next_pend = QPCD_PEND_NONE;
                next_state = QPCD_IDLE;
            end
        end
        else if (stop_p)
        begin
            next_drive_low = 1'b0;
            next_bit_cnt = 4'h0;
            next_state = QPCD_IDLE;
            if (pend != QPCD_PEND_NONE)
            begin
                next_nv_cnt = 32'h0;
                next_state = QPCD_NV_WAIT;
            end
        end
        else if (start_p)
        begin
            next_drive_low = 1'b0;
            next_bit_cnt = 4'h0;
            next_pend = QPCD_PEND_NONE;
            next_state = QPCD_ID;
        end
        else if (state == QPCD_INC_DEC)
        begin
            // Step on the fall: the rise that opens a stop must not step
            if (scl_fall)
            begin
                if (sda_lvl && wiper_position_reg[pot_sel] != TAP_MAX)
                begin
                    next_wiper[pot_sel] = wiper_position_reg[pot_sel] + 8'h01;
                end
                else if (!sda_lvl && wiper_position_reg[pot_sel] != TAP_MIN)
                begin
                    next_wiper[pot_sel] = wiper_position_reg[pot_sel] - 8'h01;
                end
            end
        end
        else if (state == QPCD_DATA_TX)
        begin
            if (scl_rise)
            begin
                next_bit_cnt = bit_cnt + 4'h1;
                if (bit_cnt == BIT_CNT_ACK)
                begin
                    next_master_ack = ~sda_lvl;
                end
            end
            if (scl_fall)
            begin
                if (bit_cnt < BIT_CNT_ACK)
                begin
                    // Rotate so a repeated read sends the same byte again
                    next_shreg = {shreg[6:0], shreg[7]};
                    next_drive_low = ~shreg[6];
                end
                else if (bit_cnt == BIT_CNT_ACK)
                begin
                    next_drive_low = 1'b0;
                end
                else if (master_ack)
                begin
                    next_bit_cnt = 4'h0;
                    next_shreg = {shreg[6:0], shreg[7]};
                    next_drive_low = ~shreg[6];
                end
                else
                begin
                    next_drive_low = 1'b0;
                    next_state = QPCD_IDLE;
                end
            end
        end
        else if (state != QPCD_IDLE)
        begin
            if (scl_rise)
            begin
                if (bit_cnt < BIT_CNT_ACK)
                begin
                    next_shreg = {shreg[6:0], sda_lvl};
                end
                next_bit_cnt = bit_cnt + 4'h1;
            end
            if (scl_fall && bit_cnt == BIT_CNT_ACK)
            begin
                if (accept)
                begin
                    next_drive_low = 1'b1;
                end
                else
                begin
                    next_state = QPCD_IDLE;
                end
            end
            if (scl_fall && bit_cnt == BIT_CNT_DONE)
            begin
                next_drive_low = 1'b0;
                next_bit_cnt = 4'h0;
                next_state = QPCD_IDLE;
                case (state)
                    QPCD_ID: next_state = QPCD_INSTR;
                    QPCD_INSTR:
                    begin
                        next_instr = shreg;
                        case (shreg[7:4])
                            OP_RD_WIPER:
                            begin
                                next_shreg = wiper_position_reg[shreg[1:0]];
                                next_drive_low = ~wiper_position_reg[shreg[1:0]][7];
                                next_state = QPCD_DATA_TX;
                            end
                            OP_RD_SETTING:
                            begin
                                next_shreg = stored_setting_reg[rx_addr];
                                next_drive_low = ~stored_setting_reg[rx_addr][7];
                                next_state = QPCD_DATA_TX;
                            end
                            OP_WR_WIPER, OP_WR_SETTING: next_state = QPCD_DATA_RX;
                            OP_XFR_TO_WIPER:
                            begin
                                next_wiper[shreg[1:0]] = stored_setting_reg[rx_addr];
                            end
                            OP_XFR_TO_SETTING:
                            begin
                                next_pend = QPCD_PEND_SINGLE;
                                next_pend_addr = rx_addr;
                                next_pend_data = wiper_position_reg[shreg[1:0]];
                            end
                            OP_GLOBAL_LOAD:
                            begin
                                for (int p = 0; p < POTS; p++)
                                begin
                                    next_wiper[p] =
                                        stored_setting_reg[setting_addr(2'(p), shreg[3:2])];
                                end
                            end
                            OP_GLOBAL_SAVE:
                            begin
                                next_pend = QPCD_PEND_GLOBAL;
                                next_pend_addr = {2'h0, shreg[3:2]};
                            end
                            OP_INC_DEC: next_state = QPCD_INC_DEC;
                            default: next_state = QPCD_IDLE;
                        endcase
                    end
                    QPCD_DATA_RX:
                    begin
                        // Extra bytes after the data byte are not acknowledged
                        if (opcode == OP_WR_WIPER)
                        begin
                            next_wiper[pot_sel] = shreg;
                        end
                        else
                        begin
                            next_pend = QPCD_PEND_SINGLE;
                            next_pend_addr = setting_addr(pot_sel, set_idx);
                            next_pend_data = shreg;
                        end
                    end
                    default: next_state = QPCD_IDLE;
                endcase
            end
        end
    end

    // ********************************************************
    // Physical wiper follows after the response delay
    // ********************************************************
    always_comb
    begin
        wiper_differs = 1'b0;
        for (int p = 0; p < POTS; p++)
        begin
            wiper_differs = wiper_differs | (phys_tap[p] != wiper_position_reg[p]);
        end
        next_phys_tap = phys_tap;
        next_resp_cnt = 16'h0;
        if (wiper_differs)
        begin
            next_resp_cnt = resp_cnt + 16'h1;
            if (resp_cnt >= 16'(WIPER_RESPONSE_CYC - 1))
            begin
                next_phys_tap = wiper_position_reg;
                next_resp_cnt = 16'h0;
            end
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            state <= QPCD_IDLE;
            pend <= QPCD_PEND_NONE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            instr <= 8'h00;
            pend_data <= 8'h00;
            pend_addr <= 4'h0;
            drive_low <= 1'b0;
            master_ack <= 1'b0;
            nv_cnt <= 32'h0;
            resp_cnt <= 16'h0;
            for (int p = 0; p < POTS; p++)
            begin
                wiper_position_reg[p] <= RESET_TAP;
                phys_tap[p] <= RESET_TAP;
            end
            for (int s = 0; s < POTS*SETTINGS_PER_POT; s++)
            begin
                stored_setting_reg[s] <= RESET_SETTING;
            end
        end
        else if (ce_in)
        begin
            state <= next_state;
            pend <= next_pend;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            instr <= next_instr;
            pend_data <= next_pend_data;
            pend_addr <= next_pend_addr;
            drive_low <= next_drive_low;
            master_ack <= next_master_ack;
            nv_cnt <= next_nv_cnt;
            resp_cnt <= next_resp_cnt;
            wiper_position_reg <= next_wiper;
            phys_tap <= next_phys_tap;
            stored_setting_reg <= next_stored;
        end
    end

    // Open drain: only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe_out = drive_low;
    assign wiper_tap_out = {phys_tap[3], phys_tap[2], phys_tap[1], phys_tap[0]};
    assign nv_busy_out = (state == QPCD_NV_WAIT);
    assign inc_dec_active_out = (state == QPCD_INC_DEC);
endmodule

// *** dv/qpcd_sva.sv ***
// Port assertions for the quad pot command decoder
`timescale 1ns/1ps
module qpcd_sva
    import qpcd_pkg::*;
#(
    parameter int NV_WRITE_CYC = NV_WRITE_CYC_DEFAULT
)
(
    // Clock and control
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire logic ce_in,
    // Link and straps
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic [3:0] address_strap_pins_in,
    // Wipers and status
    input wire logic [31:0] wiper_tap_out,
    input wire logic nv_busy_out,
    input wire logic inc_dec_active_out
);
    // ****************************************
    // Cycle counters
    // ****************************************
    int busy_cnt;
    int next_busy_cnt;
    int step_cnt;
    int next_step_cnt;
    always_comb
    begin
        next_busy_cnt = nv_busy_out ? busy_cnt + 1 : 0;
        next_step_cnt = inc_dec_active_out ? step_cnt + 1 : 0;
    end
    always_ff @(posedge clk_sys_in)
    begin
        busy_cnt <= srst_in ? 0 : next_busy_cnt;
        step_cnt <= srst_in ? 0 : next_step_cnt;
    end
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);
    chk_drive_low: assert property (sda_out == 1'b0)
        else $error("sda value high");
    chk_nv_length: assert property ($fell(nv_busy_out) |-> busy_cnt == NV_WRITE_CYC)
        else $error("write cycle length wrong");
    chk_nv_silent: assert property (nv_busy_out |-> !sda_oe_out && !inc_dec_active_out)
        else $error("activity during write cycle");
    chk_nv_after_stop: assert property ($rose(nv_busy_out) |-> scl_in && sda_in)
        else $error("write cycle not after stop");
    chk_ack_rise: assert property ($rose(sda_oe_out) |-> !scl_in && !$past(scl_in))
        else $error("drive began with clock high");
    chk_ack_fall: assert property ($fell(sda_oe_out) |-> !scl_in)
        else $error("release with clock high");
    // Sync lag moves the data line after the fall, so only settled high phases are checked
    chk_oe_hold: assert property (scl_in && $past(scl_in) && $past(scl_in, 2) |-> $stable(sda_oe_out))
        else $error("data moved while clock high");
    chk_step_no_ack: assert property (step_cnt > 16 |-> !sda_oe_out)
        else $error("acknowledge in step mode");
    chk_step_end: assert property ($fell(inc_dec_active_out) |-> scl_in && sda_in)
        else $error("step mode left without stop");
    cover property ($rose(nv_busy_out));
    cover property ($rose(inc_dec_active_out));
    cover property ($changed(wiper_tap_out));
endmodule

// *** dv/qpcd_master.sv ***
// Two-wire bus master model for the pot decoder
`timescale 1ns/1ps
module qpcd_master
(
    // Clock and wire level
    input wire logic clk_sys_in,
    input wire logic sda_line_in,
    // Master drive, data high means released to the pull-up
    output logic scl_out,
    output logic sda_out
);
    initial
    begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    // Quarter of the 160 ns bit time
    task q;
        repeat (2) @(negedge clk_sys_in);
    endtask
    task start;
        sda_out = 1'b1;
        scl_out = 1'b1;
        q();
        sda_out = 1'b0;
        q();
        scl_out = 1'b0;
        q();
    endtask
    task stop;
        sda_out = 1'b0;
        q();
        scl_out = 1'b1;
        q();
        sda_out = 1'b1;
        q();
    endtask
    task bit_io(input logic b, output logic r);
        sda_out = b;
        q();
        scl_out = 1'b1;
        q();
        r = sda_line_in;
        q();
        scl_out = 1'b0;
        q();
    endtask
    task wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task rbyte(input logic master_acknowledge, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(~master_acknowledge, r);
    endtask
endmodule

// *** dv/tb.sv ***
// Self-checking bench for the quad pot command decoder
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
    $display("Error %s expected %0h seen %0h", n, e, g); end end
module tb;
    import qpcd_pkg::*;
    localparam int NV_WRITE_CYC = 20;
    localparam logic [7:0] IDB = 8'hA6;
    logic clk_sys_in;
    logic srst_in;
    logic scl;
    logic m_sda;
    logic sda_w;
    logic oe;
    logic [31:0] taps;
    logic busy;
    logic incdec;
    logic [3:0] strap = 4'h6;
    int errors;
    int samples_checked;
    int cyc;
    logic a1;
    logic a2;
    logic a3;
    logic [7:0] d1;
    logic [7:0] d2;
    // Open-drain wire with pull-up
    assign sda_w = oe ? 1'b0 : m_sda;
    qpcd_decoder #(.NV_WRITE_CYC(NV_WRITE_CYC), .DEVICE_TYPE(4'hA)) dut (
        .clk_sys_in(clk_sys_in), .srst_in(srst_in), .ce_in(1'b1), .scl_in(scl),
        .sda_in(sda_w), .sda_out(), .sda_oe_out(oe), .address_strap_pins_in(strap),
        .wiper_tap_out(taps), .nv_busy_out(busy), .inc_dec_active_out(incdec));
    qpcd_master m (.clk_sys_in(clk_sys_in), .sda_line_in(sda_w), .scl_out(scl), .sda_out(m_sda));
    initial
    begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            stop_test();
        end
    end
    task stop_test;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task cmd(input logic [7:0] id, input logic [7:0] ins);
        m.start();
        m.wbyte(id, a1);
        m.wbyte(ins, a2);
    endtask
    task wr_wiper(input logic [1:0] p, input logic [7:0] v);
        cmd(IDB, {6'h28, p});
        m.wbyte(v, a3);
        m.stop();
        `CHK("wr acks", 3'h7, {a1, a2, a3})
    endtask
    task nv_wait;
        for (int i = 0; i < 10 && busy !== 1'b1; i++)
            @(negedge clk_sys_in);
        `CHK("nv busy", 1'b1, busy)
    endtask
    // Covers both the wiper lag and a short write cycle
    task settle;
        repeat (WIPER_RESPONSE_CYC + 10) @(negedge clk_sys_in);
    endtask
    task t_wiper;
        wr_wiper(2'h2, 8'hA5);
        `CHK("tap lag", 8'h00, taps[23:16])
        settle();
        `CHK("tap2", 8'hA5, taps[23:16])
        cmd(IDB, 8'h9E);
        m.rbyte(1'b1, d1);
        m.rbyte(1'b0, d2);
        m.stop();
        `CHK("rd wiper", 16'hA5A5, {d1, d2})
    endtask
    task t_refuse;
        cmd(8'hA7, 8'hA2);
        m.stop();
        `CHK("bad strap", 1'b0, a1)
        cmd(8'h26, 8'hA2);
        m.stop();
        `CHK("bad type", 1'b0, a1)
        cmd(IDB, 8'h32);
        m.stop();
        `CHK("bad op", 2'h2, {a1, a2})
        // Taps lag the registers, so wait before judging that nothing moved
        settle();
        `CHK("no change", 32'h00A50000, taps)
    endtask
    task t_setting;
        cmd(IDB, 8'hC9);
        m.wbyte(8'h3C, a3);
        m.stop();
        `CHK("set acks", 3'h7, {a1, a2, a3})
        nv_wait();
        m.start();
        m.wbyte(IDB, a1);
        m.stop();
        `CHK("busy id", 1'b0, a1)
        cmd(IDB, 8'hB9);
        m.rbyte(1'b0, d1);
        m.stop();
        `CHK("rd set", 8'h3C, d1)
    endtask
    task t_xfr;
        cmd(IDB, 8'hD9);
        m.stop();
        `CHK("xfr acks", 2'h3, {a1, a2})
        settle();
        `CHK("xfr load", 8'h3C, taps[15:8])
        cmd(IDB, 8'hE2);
        m.stop();
        nv_wait();
        settle();
        cmd(IDB, 8'hB2);
        m.rbyte(1'b0, d1);
        m.stop();
        `CHK("xfr save", 8'hA5, d1)
    endtask
    task t_global;
        cmd(IDB, 8'h84);
        m.stop();
        nv_wait();
        settle();
        cmd(IDB, 8'hB6);
        m.rbyte(1'b0, d1);
        m.stop();
        `CHK("gl save", 8'hA5, d1)
        cmd(IDB, 8'h18);
        m.stop();
        settle();
        `CHK("gl load", 32'h00003C00, taps)
    endtask
    task t_incdec;
        cmd(IDB, 8'h20);
        // Mode flag follows the ninth clock fall after the sync lag
        repeat (2) @(negedge clk_sys_in);
        `CHK("step mode", 3'h7, {a1, a2, incdec})
        repeat (2) m.bit_io(1'b0, a3);
        repeat (3) m.bit_io(1'b1, a3);
        m.stop();
        settle();
        `CHK("step end", 1'b0, incdec)
        `CHK("steps", 8'h03, taps[7:0])
        wr_wiper(2'h3, 8'hFE);
        cmd(IDB, 8'h23);
        repeat (3) m.bit_io(1'b1, a3);
        m.stop();
        settle();
        `CHK("top sat", 8'hFF, taps[31:24])
    endtask
    initial
    begin
        srst_in = 1'b1;
        repeat (4) @(negedge clk_sys_in);
        srst_in = 1'b0;
        repeat (4) @(negedge clk_sys_in);
        `CHK("reset", 35'h0, {oe, busy, incdec, taps})
        t_wiper();
        t_refuse();
        t_setting();
        t_xfr();
        t_global();
        t_incdec();
        stop_test();
    end
endmodule
bind qpcd_decoder qpcd_sva #(.NV_WRITE_CYC(NV_WRITE_CYC)) u_sva (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in), .ce_in(ce_in), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .address_strap_pins_in(address_strap_pins_in), .wiper_tap_out(wiper_tap_out),
    .nv_busy_out(nv_busy_out), .inc_dec_active_out(inc_dec_active_out));
